// *** core/fnc_host.sv ***
// Host controller that issues reset, identify and query commands to a NOR flash
// What this block does
// - Write needs select, strobe low, gate high
// - Broken sequence needs a reset command
// - Reset, query or lockout leaves autoselect mode
// - Two unlocks plus autoselect enter autoselect
// - Query command 98h at 55h
// - Reset command leaves query mode
module fnc_host
  import fnc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic [7:0] sw_addr, // Register byte address
  input wire logic [31:0] sw_wdata, // Register write data
  input wire logic sw_wr, // Register write strobe
  input wire logic sw_rd, // Register read strobe
  output logic [31:0] sw_rdata, // Read data, cycle after strobe
  input wire logic lockout_det, // Supply below lockout_threshold
  output logic [19:0] fl_addr, // Flash address pins
  output logic [15:0] fl_dq_out, // Flash data, driven value
  output logic fl_dq_oe, // Flash data output enable
  input wire logic [15:0] fl_dq_in, // Flash data, sensed value
  output logic fl_ce_n, // Flash chip select
  output logic fl_we_n, // Flash write strobe
  output logic fl_oe_n // Flash output gate
);

  typedef enum logic [1:0] {
    SQ_IDLE,
    SQ_ISSUE,
    SQ_WAIT
  } fnc_sq_e;

  fnc_sq_e state; // Sequencer state
  fnc_mode_e mode; // Believed flash mode
  logic [2:0] op_q; // Operation in progress
  logic [3:0] idx; // Step within the operation
  logic [19:0] addr_reg; // Software target address
  logic [15:0] rdata_reg; // Last data read from flash
  logic need_reset; // Flash state unknown
  logic mismatch; // Query table check failed
  logic refused; // Last order was refused
  logic l1, l2, l3; // Lockout synchroniser
  logic lockout; // Filtered lockout level
  logic st_wr; // Step is a write
  logic [19:0] st_addr; // Step address
  logic [15:0] st_data; // Step write data
  logic [15:0] st_exp; // Step expected read data
  logic st_last; // Final step of the operation
  logic ctrl_wr; // Control register written
  logic [2:0] op_req; // Requested operation
  logic op_known; // Requested code is defined
  logic op_mode_ok; // Request fits the flash mode
  logic op_ok; // Request accepted
  logic cy_start; // Launch a bus cycle
  logic cy_done; // Bus cycle finished
  logic [15:0] cy_rdata; // Data from the bus cycle
  logic [31:0] status_word; // Status register view
  logic [31:0] read_mux; // Selected register

  //////////////////////////////////////////////////////////////////////////////
  // Order decode
  assign ctrl_wr = sw_wr && (sw_addr == REG_CTRL);
  assign op_req = sw_wdata[2:0];
  assign op_known = (op_req >= OP_RESET) && (op_req <= OP_VERIFY);
  // query entry from array or autoselect
  assign op_mode_ok = (op_req == OP_QUERY) ? (mode != FNC_MODE_QUERY) :
                      (op_req == OP_AUTOSEL) ? (mode == FNC_MODE_ARRAY) :
                      (op_req == OP_VERIFY) ? (mode == FNC_MODE_QUERY) : 1'b1;
  assign op_ok = ctrl_wr && op_known && (state == SQ_IDLE) && !lockout && op_mode_ok &&
                 (!need_reset || op_req == OP_RESET);
  assign cy_start = (state == SQ_ISSUE);

  // Step table for every operation
  always_comb begin
    st_wr = 1'b1;
    st_addr = RESET_ADDR;
    st_data = RESET_CMD;
    st_exp = 16'h0000;
    st_last = 1'b1;
    unique case (op_q)
      OP_AUTOSEL: begin
        st_last = (idx == 4'h2);
        st_addr = (idx == 4'h1) ? UNLOCK2_ADDR : UNLOCK1_ADDR;
        st_data = (idx == 4'h0) ? UNLOCK1_DATA :
                  (idx == 4'h1) ? UNLOCK2_DATA : AUTOSEL_CMD;
      end
      OP_QUERY: begin
        st_addr = QUERY_ADDR;
        st_data = QUERY_CMD;
      end
      OP_READ: begin
        st_wr = 1'b0;
        st_addr = addr_reg;
      end
      OP_VERIFY: begin
        st_wr = 1'b0;
        st_addr = PRI_BASE + {16'h0000, idx};
        st_last = (idx == PRI_LAST_IDX);
        unique case (idx)
          4'h0: st_exp = PRI_P;
          4'h1: st_exp = PRI_R;
          4'h2: st_exp = PRI_I;
          4'h3: st_exp = PRI_MAJOR;
          4'h4: st_exp = PRI_MINOR;
          4'h5: st_exp = PRI_UNLOCK_TECH;
          4'h6: st_exp = PRI_SUSPEND;
          4'h7: st_exp = PRI_PROT_GROUP;
          4'h8: st_exp = PRI_TEMP_UNPROT;
          default: st_exp = PRI_SCHEME;
        endcase
      end
      default: begin
        st_addr = RESET_ADDR;
        st_data = RESET_CMD;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Lockout pin synchroniser; a change counts once two stages agree
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      l1 <= 1'b1;
      l2 <= 1'b1;
      l3 <= 1'b1;
      lockout <= 1'b1;
    end else begin
      l1 <= lockout_det;
      l2 <= l1;
      l3 <= l2;
      if (l2 == l3) lockout <= l3;
    end
  end

  // Sequencer and mode tracking
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= SQ_IDLE;
      mode <= FNC_MODE_ARRAY;
      op_q <= OP_RESET;
      idx <= 4'h0;
      need_reset <= 1'b0;
    end else if (lockout) begin
      state <= SQ_IDLE;
      mode <= FNC_MODE_ARRAY;
      idx <= 4'h0;
      if (state != SQ_IDLE) need_reset <= 1'b1;
    end else begin
      unique case (state)
        SQ_IDLE: if (op_ok) begin
          op_q <= op_req;
          idx <= 4'h0;
          state <= SQ_ISSUE;
        end
        SQ_ISSUE: state <= SQ_WAIT;
        SQ_WAIT: if (cy_done) begin
          if (st_last) begin
            state <= SQ_IDLE;
            if (op_q == OP_RESET) begin
              mode <= FNC_MODE_ARRAY;
              need_reset <= 1'b0;
            end
            if (op_q == OP_AUTOSEL) mode <= FNC_MODE_AUTOSEL;
            if (op_q == OP_QUERY) mode <= FNC_MODE_QUERY;
          end else begin
            idx <= idx + 4'h1;
            state <= SQ_ISSUE;
          end
        end
        default: state <= SQ_IDLE;
      endcase
    end
  end

  // Software registers and flags
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_reg <= 20'h00000;
      rdata_reg <= 16'h0000;
      mismatch <= 1'b0;
      refused <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == REG_ADDR) addr_reg <= sw_wdata[19:0];
      if (ctrl_wr) refused <= !op_ok;
      if (state == SQ_WAIT && cy_done && !st_wr) rdata_reg <= cy_rdata;
      if (op_ok && op_req == OP_VERIFY) begin
        mismatch <= 1'b0;
      end else if (state == SQ_WAIT && cy_done && op_q == OP_VERIFY && cy_rdata != st_exp) begin
        mismatch <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port, data valid only in the cycle after the strobe
  assign status_word = {25'h0000000, refused, mismatch, need_reset, lockout, mode,
                        state != SQ_IDLE};
  assign read_mux = (sw_addr == REG_ADDR) ? {12'h000, addr_reg} :
                    (sw_addr == REG_STATUS) ? status_word :
                    (sw_addr == REG_RDATA) ? {16'h0000, rdata_reg} : 32'h00000000;

  always_ff @(posedge clk) begin
    if (sys_rst) sw_rdata <= 32'h00000000;
    else sw_rdata <= sw_rd ? read_mux : 32'h00000000;
  end

  // Bus cycle engine
  fnc_cycle u_cycle (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(cy_start),
    .is_write(st_wr),
    .addr(st_addr),
    .wdata(st_data),
    .abort(lockout),
    .done(cy_done),
    .rdata(cy_rdata),
    .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe),
    .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n)
  );

endmodule

// *** core/fnc_pkg.sv ***
// Shared constants and types for the flash command host controller
package fnc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing, in ns and in cycles of the 250 MHz system clock
  localparam int CLK_NS = 4;
  // Address setup before the write strobe falls
  localparam int T_SETUP_NS = 12;
  // Write strobe low time
  localparam int T_WP_NS = 40;
  // Data hold after the write strobe rises
  localparam int T_HOLD_NS = 12;
  // Output access time after the output gate falls
  localparam int T_ACC_NS = 80;
  // Chip select high time between bus cycles
  localparam int T_GAP_NS = 20;
  // Least times round up to whole cycles
  localparam logic [7:0] C_SETUP = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] C_WP = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] C_HOLD = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] C_ACC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] C_GAP = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  // Cycles the data bus needs to pass the input synchroniser
  localparam logic [7:0] C_SYNC = 8'h03;

  //////////////////////////////////////////////////////////////////////////////
  // Software register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  // Operation codes written to the control register
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_AUTOSEL = 3'h2;
  localparam logic [2:0] OP_QUERY = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;
  localparam logic [2:0] OP_VERIFY = 3'h5;
  // Status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_MODE = 1;
  localparam int ST_LOCKOUT = 3;
  localparam int ST_NEED_RESET = 4;
  localparam int ST_MISMATCH = 5;
  localparam int ST_REFUSED = 6;

  //////////////////////////////////////////////////////////////////////////////
  // Flash command cycles, word addresses
  localparam logic [19:0] UNLOCK1_ADDR = 20'h00555;
  localparam logic [19:0] UNLOCK2_ADDR = 20'h002AA;
  localparam logic [19:0] QUERY_ADDR = 20'h00055;
  localparam logic [19:0] RESET_ADDR = 20'h00000;
  localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] AUTOSEL_CMD = 16'h0090;
  localparam logic [15:0] QUERY_CMD = 16'h0098;
  localparam logic [15:0] RESET_CMD = 16'h00F0;

  //////////////////////////////////////////////////////////////////////////////
  // Extended query table expected contents
  localparam logic [19:0] PRI_BASE = 20'h00040;
  localparam logic [3:0] PRI_LAST_IDX = 4'h9;
  localparam logic [15:0] PRI_P = 16'h0050;
  localparam logic [15:0] PRI_R = 16'h0052;
  localparam logic [15:0] PRI_I = 16'h0049;
  localparam logic [15:0] PRI_MAJOR = 16'h0031;
  localparam logic [15:0] PRI_MINOR = 16'h0033;
  localparam logic [15:0] PRI_UNLOCK_TECH = 16'h0008;
  localparam logic [15:0] PRI_SUSPEND = 16'h0002;
  localparam logic [15:0] PRI_PROT_GROUP = 16'h0001;
  localparam logic [15:0] PRI_TEMP_UNPROT = 16'h0001;
  localparam logic [15:0] PRI_SCHEME = 16'h0004;

  // Mode the flash is believed to be in
  typedef enum logic [1:0] {
    FNC_MODE_ARRAY,
    FNC_MODE_AUTOSEL,
    FNC_MODE_QUERY
  } fnc_mode_e;

endpackage

// *** core/fnc_cycle.sv ***
// One flash bus cycle, read or write, on the asynchronous pins
module fnc_cycle
  import fnc_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic start, // Begin a cycle, taken when idle
  input wire logic is_write, // Cycle kind with start
  input wire logic [19:0] addr, // Word address with start
  input wire logic [15:0] wdata, // Write data with start
  input wire logic abort, // Drop the cycle, pins to idle
  output logic done, // Cycle finished, one pulse
  output logic [15:0] rdata, // Captured read data
  output logic [19:0] fl_addr, // Flash address pins
  output logic [15:0] fl_dq_out, // Flash data, driven value
  output logic fl_dq_oe, // Flash data output enable
  input wire logic [15:0] fl_dq_in, // Flash data, sensed value
  output logic fl_ce_n, // Flash chip select
  output logic fl_we_n, // Flash write strobe
  output logic fl_oe_n // Flash output gate
);

  typedef enum logic [2:0] {
    CY_IDLE,
    CY_SETUP,
    CY_PULSE,
    CY_HOLD,
    CY_SETTLE,
    CY_GAP
  } fnc_cy_e;

  fnc_cy_e state; // Current phase
  fnc_cy_e next_state; // Phase after this edge
  logic [7:0] cnt; // Cycles spent in the phase
  logic [7:0] limit; // Length of the current phase
  logic wr_q; // Latched cycle kind
  logic next_wr; // Cycle kind seen by the pins
  logic [15:0] s1, s2, s3; // Data bus synchroniser
  logic leave; // Current phase ends
  logic capture; // Read data agreed and taken
  logic drive_ce; // Chip select wanted low
  logic drive_we; // Write strobe wanted low
  logic drive_oe; // Output gate wanted low
  logic drive_dq; // Data bus wanted driven

  //////////////////////////////////////////////////////////////////////////////
  // Phase lengths and decode
  assign limit = (state == CY_SETUP) ? C_SETUP :
                 (state == CY_PULSE) ? (wr_q ? C_WP : C_ACC) :
                 (state == CY_HOLD) ? C_HOLD :
                 (state == CY_GAP) ? C_GAP : 8'h01;
  // Sampling waits for two synchroniser stages to agree
  assign capture = (state == CY_SETTLE) && (cnt >= C_SYNC) && (s2 == s3);
  assign leave = (state == CY_SETTLE) ? capture : (cnt >= limit);
  assign done = (state == CY_GAP) && leave;
  assign next_wr = (state == CY_IDLE && start) ? is_write : wr_q;

  // Phase sequence: writes hold, reads settle
  always_comb begin
    next_state = state;
    unique case (state)
      CY_IDLE: if (start) next_state = CY_SETUP;
      CY_SETUP: if (leave) next_state = CY_PULSE;
      CY_PULSE: if (leave) next_state = wr_q ? CY_HOLD : CY_SETTLE;
      CY_HOLD: if (leave) next_state = CY_GAP;
      CY_SETTLE: if (leave) next_state = CY_GAP;
      CY_GAP: if (leave) next_state = CY_IDLE;
    endcase
  end

  assign drive_ce = (next_state != CY_IDLE) && (next_state != CY_GAP);
  assign drive_we = next_wr && (next_state == CY_PULSE);
  // Output gate stays high through every write cycle
  assign drive_oe = !next_wr && (next_state == CY_PULSE || next_state == CY_SETTLE);
  assign drive_dq = next_wr && drive_ce;

  //////////////////////////////////////////////////////////////////////////////
  // Phase state and latched request
  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      state <= CY_IDLE;
      cnt <= 8'h01;
    end else begin
      state <= next_state;
      cnt <= (leave || state == CY_IDLE) ? 8'h01 : cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_q <= 1'b0;
      fl_addr <= 20'h00000;
      fl_dq_out <= 16'h0000;
    end else if (state == CY_IDLE && start) begin
      wr_q <= is_write;
      fl_addr <= addr;
      fl_dq_out <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_oe <= 1'b0;
    end else begin
      fl_ce_n <= !drive_ce;
      fl_we_n <= !drive_we;
      fl_oe_n <= !drive_oe;
      fl_dq_oe <= drive_dq;
    end
  end

  // Data bus synchroniser and read capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1 <= 16'h0000;
      s2 <= 16'h0000;
      s3 <= 16'h0000;
      rdata <= 16'h0000;
    end else begin
      s1 <= fl_dq_in;
      s2 <= s1;
      s3 <= s2;
      if (capture) rdata <= s3;
    end
  end

endmodule

// *** test/fnc_host_assertions.sv ***
// Checker on the flash pins of the host controller, bound to its top
module fnc_host_chk (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic lockout_det, // Supply below threshold
  input wire logic [19:0] fl_addr, // Address pins
  input wire logic [15:0] fl_dq_out, // Driven data
  input wire logic fl_dq_oe, // Data enable
  input wire logic fl_ce_n, // Chip select
  input wire logic fl_we_n, // Write strobe
  input wire logic fl_oe_n // Output gate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  // strobe only with select, gate high
  a_write_gate_high: assert property (!fl_we_n |-> fl_oe_n && !fl_ce_n)
    else $error("write strobe without select or with gate low");
  // no drive while the gate is open
  a_no_bus_fight: assert property (!fl_oe_n |-> !fl_dq_oe)
    else $error("data driven while output gate low");
  // pins idle when reset lets go
  a_reset_pins_idle: assert property ($fell(sys_rst) |-> fl_ce_n && fl_we_n && fl_oe_n)
    else $error("strobes not idle after reset");
  // address and data still under the pulse; lockout aborts legally
  a_addr_data_held: assert property (disable iff (sys_rst || lockout_det)
    !fl_we_n |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address or data moved under write pulse");
  // select settles three cycles before the strobe
  a_setup_before_we: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n, 3))
    else $error("write strobe without address setup");
  a_we_pulse_width: assert property (disable iff (sys_rst || lockout_det)
    $fell(fl_we_n) |-> (!fl_we_n)[*8] ##1 !fl_we_n ##1 !fl_we_n ##1 fl_we_n)
    else $error("write pulse width wrong");
  // data held three cycles after the strobe rises
  a_hold_after_we: assert property (disable iff (sys_rst || lockout_det)
    $rose(fl_we_n) |-> (!fl_ce_n && fl_dq_oe && $stable(fl_dq_out))[*3] ##1 fl_ce_n)
    else $error("data hold after write pulse wrong");
  // no strobe once low supply has passed the synchroniser
  a_no_write_lockout: assert property (lockout_det[*6] |-> fl_we_n)
    else $error("write during lockout");
  // command cycles carry their fixed addresses
  a_cmd_addr_pairs: assert property ($fell(fl_we_n) |->
    (fl_dq_out != 16'h00AA || fl_addr == 20'h00555) &&
    (fl_dq_out != 16'h0055 || fl_addr == 20'h002AA) &&
    (fl_dq_out != 16'h0090 || fl_addr == 20'h00555) &&
    (fl_dq_out != 16'h0098 || fl_addr == 20'h00055))
    else $error("command written at wrong address");
endmodule

bind fnc_host fnc_host_chk chk_u (.clk(clk), .sys_rst(sys_rst), .lockout_det(lockout_det),
  .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_ce_n(fl_ce_n),
  .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));

// *** test/fnc_flash_model.sv ***
// Behavioural flash device: command decode, identify and query reads
module fnc_flash_model #(
  parameter logic [15:0] MFR_ID = 16'h00C3, // Arbitrary value
  parameter logic [15:0] DEV_ID = 16'h2B5E, // Arbitrary value
  parameter logic [4:0] PROT_SEC = 5'h03 // Protected sector_addr
) (
  input wire logic [19:0] fl_addr, // Address pins
  input wire logic [15:0] fl_dq_out, // Host data value
  input wire logic fl_ce_n, // Chip select
  input wire logic fl_we_n, // Write strobe
  input wire logic fl_oe_n, // Output gate
  input wire logic lockout_det, // Supply below lockout_threshold
  input wire logic bad_q, // Corrupt query word 45h
  input wire logic slow, // Late read data
  output logic [15:0] dq // Value the device shows
);
  timeunit 1ns;
  timeprecision 1ps;
  // power-up state is read-array: 0 array, 1-2 unlock, 3 autoselect, 4 query
  logic [2:0] mode = 3'h0;
  logic [19:0] a_lat = 20'h00000; // Latched write address
  logic armed = 1'h0; // Strobe fall seen before rise
  logic [15:0] last = 16'h0000; // Last value shown
  logic [15:0] v_d = 16'h0000; // Late copy of read value
  wire [15:0] v_now; // Read value now
  wire wr_act; // Write cycle active
  wire rd_en; // Read cycle active
  // write needs select and strobe low with gate high
  assign wr_act = !fl_ce_n && !fl_we_n && fl_oe_n;
  assign rd_en = !fl_ce_n && !fl_oe_n;
  function automatic logic [15:0] qword(input logic [7:0] a);
    case (a)
      8'h40: return 16'h0050;
      8'h41: return 16'h0052;
      8'h42: return 16'h0049;
      8'h43: return 16'h0031;
      8'h44: return 16'h0033;
      8'h45: return bad_q ? 16'h0009 : 16'h0008;
      8'h46: return 16'h0002;
      8'h47: return 16'h0001;
      8'h48: return 16'h0001;
      8'h49: return 16'h0004;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic logic [15:0] ident(input logic [19:0] a);
    case (a[7:0])
      8'h00: return MFR_ID;
      8'h01: return DEV_ID;
      8'h02: return (a[19:15] == PROT_SEC) ? 16'h0001 : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction
  // array contents; embedded operations never start here
  assign v_now = (mode == 3'h4) ? qword(fl_addr[7:0]) :
    (mode == 3'h3) ? ident(fl_addr) : (fl_addr[15:0] ^ 16'h5A5A);
  // Slow answer shows a stale word until it settles
  always @(v_now) v_d <= #60 v_now;
  always @(rd_en or v_now or v_d or slow) if (rd_en) last = slow ? v_d : v_now;
  // Released bus shows the inverse of the last word, never a held copy
  assign dq = rd_en ? (slow ? v_d : v_now) : ~last;
  // address taken when the later strobe falls
  always @(posedge wr_act) begin
    a_lat = fl_addr;
    armed = 1'h1;
  end
  // data taken when the first strobe rises
  always @(negedge wr_act) begin
    // drops to read-array below threshold or if already low at power-up
    if (lockout_det || !armed) mode = 3'h0;
    else if (fl_dq_out[7:0] == 8'hF0) mode = 3'h0;
    else if (fl_dq_out[7:0] == 8'h98 && a_lat == 20'h00055 && (mode == 3'h0 || mode == 3'h3))
      mode = 3'h4;
    else if (mode == 3'h0 && fl_dq_out[7:0] == 8'hAA && a_lat == 20'h00555) mode = 3'h1;
    else if (mode == 3'h1 && fl_dq_out[7:0] == 8'h55 && a_lat == 20'h002AA) mode = 3'h2;
    else if (mode == 3'h2 && fl_dq_out[7:0] == 8'h90 && a_lat == 20'h00555) mode = 3'h3;
    // broken sequence drops back; autoselect and query hold
    else if (mode < 3'h3) mode = 3'h0;
    armed = 1'h0;
  end
  // supply dip resets the command state
  always @(posedge lockout_det) mode = 3'h0;
endmodule

// *** test/fnc_host_tb.sv ***
// Self-checking bench: software orders in, flash model on the pins
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, (e), (g)); end end
module fnc_host_tb
  import fnc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MFR = 16'h00C3; // Arbitrary value
  localparam logic [15:0] DEV = 16'h2B5E; // Arbitrary value
  localparam logic [4:0] PSEC = 5'h03; // Protected sector
  logic clk, sys_rst, sw_wr, sw_rd, lockout_det, bad_q, slow; // Drives
  logic [7:0] sw_addr; // Register address
  logic [31:0] sw_wdata, sw_rdata, rv; // Bus data and last read
  logic [19:0] fl_addr; // Flash address
  logic [15:0] fl_dq_out, fl_dq_in, m_dq; // Data bus parts
  logic fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n; // Flash controls
  int n_fail = 0, comparisons = 0, k, j; // Counters and loops
  logic [15:0] qexp [10] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033,
    16'h0008, 16'h0002, 16'h0001, 16'h0001, 16'h0004}; // Query words 40h..49h
  // Bus level: host drive wins, else the device
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : m_dq;
  fnc_host dut_u (.clk(clk), .sys_rst(sys_rst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .lockout_det(lockout_det),
    .fl_addr(fl_addr), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
    .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n));
  fnc_flash_model #(.MFR_ID(MFR), .DEV_ID(DEV), .PROT_SEC(PSEC)) mdl_u (.fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .lockout_det(lockout_det), .bad_q(bad_q), .slow(slow), .dq(m_dq));
  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // One-cycle write, then a idle cycle so strobes never double-assign
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge clk);
    sw_wr <= 1'h0;
    @(posedge clk);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge clk);
    sw_rd <= 1'h0;
    #1 rv = sw_rdata;
    @(posedge clk);
  endtask
  // Poll busy under a bound; leaves status in rv
  task automatic op(input logic [2:0] c);
    int i;
    wr(REG_CTRL, {29'h0, c});
    repeat (4) @(posedge clk);
    for (i = 0; i < 600; i++) begin
      rd(REG_STATUS);
      if (rv[ST_BUSY] === 1'h0) break;
    end
    `CHK("busy_end", 1'h0, rv[ST_BUSY])
  endtask
  // Flash word read through the ADDR register
  task automatic rdw(input logic [19:0] a);
    wr(REG_ADDR, {12'h000, a});
    op(OP_READ);
    rd(REG_RDATA);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {sys_rst, lockout_det} = 2'h3;
    {sw_wr, sw_rd, bad_q, slow} = 4'h0;
    sw_addr = 8'h00;
    sw_wdata = 32'h0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (6) @(posedge clk);
    op(OP_RESET);
    `CHK("lockout", 2'h3, {rv[ST_LOCKOUT], rv[ST_REFUSED]})
    lockout_det <= 1'h0;
    repeat (10) @(posedge clk);
    rdw(20'h00123);
    `CHK("array_pwrup", 16'h0123 ^ 16'h5A5A, rv[15:0])
    for (k = 0; k < 2; k++) begin
      slow <= k[0];
      op(OP_AUTOSEL);
      `CHK("mode_asel", 3'h1, {rv[ST_REFUSED], rv[ST_MODE+:2]})
      rdw(20'h00000);
      `CHK("mfr", MFR, rv[15:0])
      rdw(20'h00001);
      `CHK("dev", DEV, rv[15:0])
      rdw({PSEC, 15'h0002});
      `CHK("prot", 16'h0001, rv[15:0])
      rdw({5'h04, 15'h0002});
      `CHK("unprot", 16'h0000, rv[15:0])
      op(OP_AUTOSEL);
      `CHK("asel_again", 3'h5, {rv[ST_REFUSED], rv[ST_MODE+:2]})
      op(OP_QUERY);
      `CHK("mode_query", 3'h2, {rv[ST_REFUSED], rv[ST_MODE+:2]})
      for (j = 0; j < 10; j++) begin
        rdw(PRI_BASE + 20'(j));
        `CHK("query_word", qexp[j], rv[15:0])
      end
      op(OP_VERIFY);
      `CHK("verify_ok", 1'h0, rv[ST_MISMATCH])
      bad_q <= 1'h1;
      op(OP_VERIFY);
      `CHK("verify_bad", 1'h1, rv[ST_MISMATCH])
      bad_q <= 1'h0;
      op(OP_RESET);
      `CHK("mode_reset", 3'h0, {rv[ST_REFUSED], rv[ST_MODE+:2]})
      rdw(20'h00ABC);
      `CHK("array_back", 16'h0ABC ^ 16'h5A5A, rv[15:0])
    end
    // Supply dip while idle in autoselect: both sides back to array
    op(OP_AUTOSEL);
    lockout_det <= 1'h1;
    repeat (20) @(posedge clk);
    lockout_det <= 1'h0;
    repeat (10) @(posedge clk);
    rdw(20'h00456);
    `CHK("dip_array", 16'h0456 ^ 16'h5A5A, rv[15:0])
    // Supply dip in mid-write: reset demanded before anything else
    wr(REG_CTRL, {29'h0, OP_QUERY});
    repeat (6) @(posedge clk);
    lockout_det <= 1'h1;
    repeat (20) @(posedge clk);
    lockout_det <= 1'h0;
    repeat (10) @(posedge clk);
    op(OP_AUTOSEL);
    `CHK("need_reset", 2'h3, {rv[ST_NEED_RESET], rv[ST_REFUSED]})
    op(OP_RESET);
    `CHK("reset_clear", 2'h0, {rv[ST_NEED_RESET], rv[ST_REFUSED]})
    // Order while busy, undefined codes and verify outside query
    wr(REG_CTRL, {29'h0, OP_QUERY});
    op(OP_RESET);
    `CHK("busy_refuse", 3'h6, {rv[ST_REFUSED], rv[ST_MODE+:2]})
    op(OP_RESET);
    op(OP_VERIFY);
    `CHK("verify_refuse", 1'h1, rv[ST_REFUSED])
    op(3'h0);
    `CHK("op0_refuse", 1'h1, rv[ST_REFUSED])
    op(3'h7);
    `CHK("op7_refuse", 1'h1, rv[ST_REFUSED])
    report_and_stop();
  end
endmodule
